// ### hw/fpc_host.sv
// fpc_host: host sequencer driving a bulk-erase flash through its strobes and supply
`timescale 1ns/1ns

module fpc_host
  import fpc_pkg::*;
#(
  parameter int ADDR_W       = 17,
  parameter int ERASE_WAIT   = ERASE_CYC,
  parameter int PROG_MAX     = PROG_PULSES_MAX,
  parameter int ERASE_MAX    = ERASE_PULSES_MAX
) (
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic              I_CMD_VALID,
  input  wire logic [1:0]        I_CMD_OP,
  input  wire logic [ADDR_W-1:0] I_CMD_ADDR,
  input  wire logic [7:0]        I_CMD_DATA,
  input  wire logic [7:0]        I_FL_DQ,
  output logic                   O_BUSY,
  output logic                   O_DONE,
  output logic                   O_FAIL,
  output logic [7:0]             O_RD_DATA,
  output logic                   O_FL_E_N,
  output logic                   O_FL_G_N,
  output logic                   O_FL_W_N,
  output logic [ADDR_W-1:0]      O_FL_ADDR,
  output logic [7:0]             O_FL_DQ,
  output logic                   O_FL_DQ_OE_N,
  output logic                   O_PROGRAMMING_SUPPLY_HIGH
);

  localparam logic [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};

  fpc_state_t        state_ff, nxt_state, ret_ff, nxt_ret, wret_ff, nxt_wret;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt, post_ff, nxt_post;
  logic [9:0]        pulses_ff, nxt_pulses;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [7:0]        data_ff, nxt_data;
  logic              pre_ff, nxt_pre;
  logic              busy_ff, nxt_busy, done_ff, nxt_done, fail_ff, nxt_fail;
  logic [7:0]        rd_ff, nxt_rd;
  logic              e_n_ff, nxt_e_n, g_n_ff, nxt_g_n, w_n_ff, nxt_w_n;
  logic [ADDR_W-1:0] fa_ff, nxt_fa;
  logic [7:0]        fd_ff, nxt_fd;
  logic              oe_n_ff, nxt_oe_n, vpp_ff, nxt_vpp;
  logic [7:0]        prog_src;

  assign prog_src = pre_ff ? DATA_ZERO : data_ff;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state  = state_ff;
    nxt_ret    = ret_ff;
    nxt_wret   = wret_ff;
    nxt_cnt    = cnt_ff;
    nxt_post   = post_ff;
    nxt_pulses = pulses_ff;
    nxt_addr   = addr_ff;
    nxt_data   = data_ff;
    nxt_pre    = pre_ff;
    nxt_busy   = busy_ff;
    nxt_done   = 1'b0;
    nxt_fail   = fail_ff;
    nxt_rd     = rd_ff;
    nxt_e_n    = e_n_ff;
    nxt_g_n    = g_n_ff;
    nxt_w_n    = w_n_ff;
    nxt_fa     = fa_ff;
    nxt_fd     = fd_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_vpp    = vpp_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (I_CMD_VALID) begin
          nxt_busy   = 1'b1;
          nxt_fail   = 1'b0;
          nxt_addr   = I_CMD_ADDR;
          nxt_data   = I_CMD_DATA;
          nxt_pulses = '0;
          nxt_pre    = 1'b0;
          nxt_cnt    = CNT_W'(VPP_UP_CYC);
          nxt_state  = S_WAIT;
          unique case (I_CMD_OP)
            OP_READ: begin
              nxt_cnt   = '0;
              nxt_wret  = S_BUSR;
              nxt_ret   = S_DONE;
            end
            OP_PROG: begin
              nxt_vpp  = 1'b1;
              nxt_wret = S_SUPRG;
            end
            OP_ERASE: begin
              nxt_vpp  = 1'b1;
              nxt_pre  = 1'b1;
              nxt_addr = '0;
              nxt_wret = S_SUPRG;
            end
            OP_RESET: begin
              nxt_vpp  = 1'b1;
              nxt_wret = S_RST1;
            end
          endcase
        end
      end
      // each command step loads a bus write, a wait after it, and a resume state
      S_SUPRG: begin
        nxt_pulses = pulses_ff + 10'h001;
        nxt_fd = CMD_SETUP_PROG; nxt_post = '0; nxt_ret = S_PRG;
        nxt_state = S_BUSW;
      end
      S_PRG: begin
        nxt_fa = addr_ff; nxt_fd = prog_src;
        nxt_post = CNT_W'(PROG_CYC); nxt_ret = S_PVER;
        nxt_state = S_BUSW;
      end
      S_PVER: begin
        nxt_fd = CMD_PROG_VER; nxt_post = CNT_W'(VERIFY_CYC); nxt_ret = S_PRD;
        nxt_state = S_BUSW;
      end
      S_PRD: begin
        nxt_ret = S_PCHK; nxt_state = S_BUSR;
      end
      S_PCHK: begin
        if (rd_ff == prog_src) begin
          nxt_pulses = '0;
          if (pre_ff && addr_ff != ADDR_LAST) begin
            nxt_addr = addr_ff + ADDR_W'(1); nxt_state = S_SUPRG;
          end else if (pre_ff) begin
            nxt_pre = 1'b0; nxt_addr = '0; nxt_state = S_SUER;
          end else begin
            nxt_state = S_RDCMD;
          end
        end else if (pulses_ff >= 10'(PROG_MAX)) begin
          nxt_fail = 1'b1; nxt_state = S_RDCMD;
        end else begin
          nxt_state = S_SUPRG;
        end
      end
      S_SUER: begin
        nxt_pulses = pulses_ff + 10'h001;
        nxt_fd = CMD_SETUP_ERASE; nxt_post = '0; nxt_ret = S_ERA;
        nxt_state = S_BUSW;
      end
      S_ERA: begin
        nxt_fd = CMD_SETUP_ERASE; nxt_post = CNT_W'(ERASE_WAIT); nxt_ret = S_EVER;
        nxt_state = S_BUSW;
      end
      S_EVER: begin
        nxt_fa = addr_ff; nxt_fd = CMD_ERASE_VER;
        nxt_post = CNT_W'(VERIFY_CYC); nxt_ret = S_ERD;
        nxt_state = S_BUSW;
      end
      S_ERD: begin
        nxt_ret = S_ECHK; nxt_state = S_BUSR;
      end
      S_ECHK: begin
        if (rd_ff == DATA_ERASED) begin
          if (addr_ff == ADDR_LAST) begin
            nxt_state = S_RDCMD;
          end else begin
            nxt_addr = addr_ff + ADDR_W'(1); nxt_state = S_EVER;
          end
        end else if (pulses_ff >= 10'(ERASE_MAX)) begin
          nxt_fail = 1'b1; nxt_state = S_RDCMD;
        end else begin
          nxt_state = S_SUER;
        end
      end
      S_RST1: begin
        nxt_fd = CMD_RESET; nxt_post = '0; nxt_ret = S_RST2;
        nxt_state = S_BUSW;
      end
      S_RST2: begin
        nxt_fd = CMD_RESET; nxt_post = '0; nxt_ret = S_VDN;
        nxt_state = S_BUSW;
      end
      S_RDCMD: begin
        nxt_fd = CMD_READ; nxt_post = '0; nxt_ret = S_VDN;
        nxt_state = S_BUSW;
      end
      S_VDN: begin
        nxt_vpp = 1'b0;
        nxt_cnt = CNT_W'(VPP_DN_CYC); nxt_wret = S_DONE; nxt_state = S_WAIT;
      end
      // address set first, data driven through the low strobe
      S_BUSW: begin
        nxt_cnt  = cnt_ff + CNT_W'(1);
        nxt_e_n  = 1'b0;
        nxt_oe_n = 1'b0;
        if (cnt_ff == CNT_W'(PH_W_FALL)) begin
          nxt_w_n = 1'b0;
        end
        if (cnt_ff == CNT_W'(PH_W_RISE)) begin
          nxt_w_n = 1'b1;
        end
        if (cnt_ff == CNT_W'(PH_W_END)) begin
          nxt_e_n = 1'b1; nxt_oe_n = 1'b1;
          nxt_cnt = post_ff; nxt_wret = ret_ff; nxt_state = S_WAIT;
        end
      end
      S_BUSR: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_e_n = 1'b0;
        nxt_g_n = 1'b0;
        nxt_oe_n = 1'b1;
        if (cnt_ff == CNT_W'(ACC_CYC)) begin
          nxt_rd = I_FL_DQ; nxt_e_n = 1'b1; nxt_g_n = 1'b1;
          nxt_cnt = '0; nxt_state = ret_ff;
        end
      end
      S_WAIT: begin
        if (cnt_ff == '0) begin
          nxt_state = wret_ff;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      S_DONE: begin
        nxt_done = 1'b1; nxt_busy = 1'b0; nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
    // bus phase counter restarts on entry to a bus cycle
    if (nxt_state != state_ff && nxt_state inside {S_BUSW, S_BUSR}) begin
      nxt_cnt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip select idles high: a single finished device stays masked
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_ff <= S_IDLE; ret_ff <= S_IDLE; wret_ff <= S_IDLE;
      cnt_ff <= '0; post_ff <= '0; pulses_ff <= '0;
      addr_ff <= '0; data_ff <= 8'h00; pre_ff <= 1'b0;
      busy_ff <= 1'b0; done_ff <= 1'b0; fail_ff <= 1'b0; rd_ff <= 8'h00;
      e_n_ff <= 1'b1; g_n_ff <= 1'b1; w_n_ff <= 1'b1;
      fa_ff <= '0; fd_ff <= 8'h00; oe_n_ff <= 1'b1; vpp_ff <= 1'b0;
    end else if (I_CE) begin
      state_ff <= nxt_state; ret_ff <= nxt_ret; wret_ff <= nxt_wret;
      cnt_ff <= nxt_cnt;
      post_ff <= nxt_post; pulses_ff <= nxt_pulses;
      addr_ff <= nxt_addr; data_ff <= nxt_data; pre_ff <= nxt_pre;
      busy_ff <= nxt_busy; done_ff <= nxt_done; fail_ff <= nxt_fail; rd_ff <= nxt_rd;
      e_n_ff <= nxt_e_n; g_n_ff <= nxt_g_n; w_n_ff <= nxt_w_n;
      fa_ff <= nxt_fa; fd_ff <= nxt_fd; oe_n_ff <= nxt_oe_n; vpp_ff <= nxt_vpp;
    end
  end

  assign O_BUSY                    = busy_ff;
  assign O_DONE                    = done_ff;
  assign O_FAIL                    = fail_ff;
  assign O_RD_DATA                 = rd_ff;
  assign O_FL_E_N                  = e_n_ff;
  assign O_FL_G_N                  = g_n_ff;
  assign O_FL_W_N                  = w_n_ff;
  assign O_FL_ADDR                 = fa_ff;
  assign O_FL_DQ                   = fd_ff;
  assign O_FL_DQ_OE_N              = oe_n_ff;
  assign O_PROGRAMMING_SUPPLY_HIGH = vpp_ff;

endmodule // fpc_host

// ### hw/fpc_pkg.sv
// fpc_pkg: command codes, bus timing and wait counts for the flash host sequencer
package fpc_pkg;

  // command register codes written on the data lines, then the erased and all-zero data values
  localparam logic [7:0] CMD_READ       = 8'h00;
  localparam logic [7:0] CMD_SETUP_ERASE = 8'h20;
  localparam logic [7:0] CMD_SETUP_PROG = 8'h40;
  localparam logic [7:0] CMD_ERASE_VER  = 8'hA0;
  localparam logic [7:0] CMD_PROG_VER   = 8'hC0;
  localparam logic [7:0] CMD_RESET      = 8'hFF;
  localparam logic [7:0] DATA_ERASED    = 8'hFF;
  localparam logic [7:0] DATA_ZERO      = 8'h00;

  // user operation codes
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_PROG  = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;

  localparam int CLK_NS = 10;
  localparam int CNT_W  = 24;

  // times in their own units
  localparam int T_SU_E_NS    = 20;
  localparam int T_W_LOW_NS   = 60;
  localparam int T_W_HOLD_NS  = 10;
  localparam int T_ACC_NS     = 200;
  localparam int T_VPP_SU_NS  = 1000;
  localparam int T_VPP_RISE_NS = 1000;
  localparam int T_VPP_FALL_NS = 1000;
  localparam int T_PROG_US    = 10;
  localparam int T_VERIFY_US  = 6;
  localparam int T_ERASE_MS   = 10;

  // least times round up to whole cycles
  localparam int SU_E_CYC   = (T_SU_E_NS + CLK_NS - 1) / CLK_NS;
  localparam int W_LOW_CYC  = (T_W_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int W_HOLD_CYC = (T_W_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPP_UP_CYC = (T_VPP_RISE_NS + T_VPP_SU_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPP_DN_CYC = (T_VPP_FALL_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CYC   = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int VERIFY_CYC = (T_VERIFY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC  = (T_ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // bus write phase marks
  localparam int PH_W_FALL = SU_E_CYC;
  localparam int PH_W_RISE = SU_E_CYC + W_LOW_CYC;
  localparam int PH_W_END  = SU_E_CYC + W_LOW_CYC + W_HOLD_CYC;

  localparam int PROG_PULSES_MAX  = 25;
  localparam int ERASE_PULSES_MAX = 1000;

  typedef enum logic [4:0] {
    S_IDLE, S_SUPRG, S_PRG, S_PVER, S_PRD, S_PCHK,
    S_SUER, S_ERA, S_EVER, S_ERD, S_ECHK,
    S_RST1, S_RST2, S_RDCMD, S_VDN,
    S_BUSW, S_BUSR, S_WAIT, S_DONE
  } fpc_state_t;

endpackage

// ### bench/fpc_flash_model.sv
// fpc_flash_model: behavioural bulk-erase flash answering the host strobes
`timescale 1ns/1ns
module fpc_flash_model #(
  parameter int AW = 3
) (
  input  wire logic          e_n,
  input  wire logic          g_n,
  input  wire logic          w_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    din,
  input  wire logic          vpp,
  output logic [7:0]         dout,
  output logic               pre_err
);
  logic [7:0]    mem [2**AW];
  logic [7:0]    cmd_ff = 8'h00;
  logic [AW-1:0] a_lat = '0;
  logic [AW-1:0] v_adr = '0;
  logic [7:0]    val;
  int            drop_p = 0;
  int            drop_e = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    pre_err = 1'b0;
  end
  ////////////////////////////////////////
  always @(negedge w_n) if (!e_n) a_lat = addr;
  // without the supply high a write changes nothing
  always @(posedge w_n) if (!e_n && vpp) begin
    if (cmd_ff == 8'h40) begin
      if (drop_p > 0 && din != 8'hFF) drop_p--;
      else mem[a_lat] &= din;
      v_adr = a_lat;
      // ffh programs nothing and doubles as the first reset write
      cmd_ff = (din == 8'hFF) ? 8'hFF : 8'h41; // stop timer: inactive until next command
    end else if (cmd_ff == 8'h20 && din == 8'h20) begin
      foreach (mem[i]) if (mem[i] != 8'h00) pre_err = 1'b1;
      if (drop_e > 0) drop_e--;
      else foreach (mem[i]) mem[i] = 8'hFF;
      cmd_ff = 8'h21;
    end else if (cmd_ff == 8'hFF && din == 8'hFF) cmd_ff = 8'h00;
    else if (din inside {8'h00, 8'h20, 8'h40, 8'hA0, 8'hC0, 8'hFF}) begin
      cmd_ff = din;
      if (din == 8'hA0) v_adr = a_lat;
    end // unknown codes keep the state
  end
  always_comb begin
    val = (cmd_ff == 8'hA0 || cmd_ff == 8'hC0) ? mem[v_adr] : mem[addr];
    // a released bus must not look like the last byte
    dout = (!e_n && !g_n) ? val : ~val;
  end
endmodule // fpc_flash_model

// ### bench/fpc_host_assertions.sv
// fpc_host_assertions: port checks of the host sequencer flash bus
`timescale 1ns/1ns
module fpc_host_assertions #(
  parameter int ADDR_W = 17
) (
  input wire logic              I_CLK_SYS,
  input wire logic              I_RST,
  input wire logic              I_CE,
  input wire logic              O_BUSY,
  input wire logic              O_DONE,
  input wire logic              O_FL_E_N,
  input wire logic              O_FL_G_N,
  input wire logic              O_FL_W_N,
  input wire logic [ADDR_W-1:0] O_FL_ADDR,
  input wire logic [7:0]        O_FL_DQ,
  input wire logic              O_FL_DQ_OE_N,
  input wire logic              O_PROGRAMMING_SUPPLY_HIGH
);
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  logic [7:0]  lastw_ff;
  logic [7:0]  nxt_lastw;
  // cycles since the strobe was last low, saturating
  always_comb begin
    nxt_gap = (!O_FL_W_N) ? 16'h0000 : ((&gap_ff) ? gap_ff : gap_ff + 16'h0001);
    nxt_lastw = (!O_FL_W_N) ? O_FL_DQ : lastw_ff;
  end
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      gap_ff <= 16'hFFFF;
      lastw_ff <= 8'h00;
    end else begin
      gap_ff <= nxt_gap;
      lastw_ff <= nxt_lastw;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  a_done_drops_busy: assert property ($rose(O_DONE) |-> $fell(O_BUSY))
    else $error("done without busy falling");
  a_done_one_cycle: assert property (O_DONE && I_CE |=> !O_DONE)
    else $error("done longer than one cycle");
  a_idle_released: assert property (!O_BUSY |-> O_FL_E_N && O_FL_W_N && O_FL_DQ_OE_N)
    else $error("flash pins held while idle");
  a_write_qual: assert property (!O_FL_W_N |-> !O_FL_E_N && !O_FL_DQ_OE_N && O_FL_G_N)
    else $error("strobe low without select or drive");
  a_write_supply: assert property (!O_FL_W_N |-> O_PROGRAMMING_SUPPLY_HIGH)
    else $error("command write with supply low");
  a_select_setup: assert property ($fell(O_FL_W_N) |-> !$past(O_FL_E_N, 2))
    else $error("select setup too short");
  a_strobe_width: assert property ($fell(O_FL_W_N) |-> (!O_FL_W_N)[*6])
    else $error("strobe pulse too short");
  a_addr_held: assert property (!O_FL_W_N |-> $stable(O_FL_ADDR) && $stable(O_FL_DQ))
    else $error("address or data moved under strobe");
  // c0h right after 40h is program data, not the verify command
  a_prog_wait: assert property ($fell(O_FL_W_N) && O_FL_DQ == 8'hC0 && lastw_ff != 8'h40
    |-> gap_ff >= 16'h03E8)
    else $error("program verify too early");
  a_verify_wait: assert property ($fell(O_FL_G_N) && O_PROGRAMMING_SUPPLY_HIGH
    |-> gap_ff >= 16'h0258)
    else $error("verify read too early");
  a_read_before_drop: assert property ($fell(O_PROGRAMMING_SUPPLY_HIGH)
    |-> lastw_ff == 8'h00 || lastw_ff == 8'hFF)
    else $error("supply dropped before read command");
endmodule // fpc_host_assertions
bind fpc_host fpc_host_assertions #(.ADDR_W(ADDR_W)) u_fpc_host_assertions (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CE(I_CE), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
  .O_FL_E_N(O_FL_E_N), .O_FL_G_N(O_FL_G_N), .O_FL_W_N(O_FL_W_N), .O_FL_ADDR(O_FL_ADDR),
  .O_FL_DQ(O_FL_DQ), .O_FL_DQ_OE_N(O_FL_DQ_OE_N),
  .O_PROGRAMMING_SUPPLY_HIGH(O_PROGRAMMING_SUPPLY_HIGH));

// ### bench/fpc_host_tb.sv
// fpc_host_tb: random and corner stimulus for the flash host sequencer
`timescale 1ns/1ns
module fpc_host_tb import fpc_pkg::*;;
  localparam int AW = 3;
  logic          clk, rst, ce, valid, busy, done, fail, e_n, g_n, w_n, oe_n, vpp, pre_err;
  logic [1:0]    op;
  logic [AW-1:0] c_addr, f_addr, a;
  logic [7:0]    c_data, rd_data, host_dq, fl_out, d;
  logic [7:0]    shadow [2**AW];
  int            bad_count = 0;
  int            total_checks = 0;
  int            cycles = 0;
  int            seed = 32'h6eea;
  wire  [7:0]    dq_bus = oe_n ? fl_out : host_dq;
  fpc_host #(.ADDR_W(AW), .ERASE_WAIT(50), .PROG_MAX(4), .ERASE_MAX(4)) u_fpc_host (
    .I_CLK_SYS(clk), .I_RST(rst), .I_CE(ce), .I_CMD_VALID(valid), .I_CMD_OP(op),
    .I_CMD_ADDR(c_addr), .I_CMD_DATA(c_data), .I_FL_DQ(dq_bus), .O_BUSY(busy),
    .O_DONE(done), .O_FAIL(fail), .O_RD_DATA(rd_data), .O_FL_E_N(e_n), .O_FL_G_N(g_n),
    .O_FL_W_N(w_n), .O_FL_ADDR(f_addr), .O_FL_DQ(host_dq), .O_FL_DQ_OE_N(oe_n),
    .O_PROGRAMMING_SUPPLY_HIGH(vpp));
  fpc_flash_model #(.AW(AW)) u_flash (.e_n(e_n), .g_n(g_n), .w_n(w_n), .addr(f_addr),
    .din(dq_bus), .vpp(vpp), .dout(fl_out), .pre_err(pre_err));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // flash bits only clear: a byte is reachable only if no 0 must turn to 1
  function automatic logic [7:0] exp_fail(input logic [7:0] old, input logic [7:0] nw);
    return {7'h00, (old & nw) != nw};
  endfunction
  // request held two extra edges while busy, which must be ignored
  task automatic run_op(input logic [1:0] o, input logic [AW-1:0] ad, input logic [7:0] dt);
    @(posedge clk);
    #1 ce = 1'b1;
    valid = 1'b1;
    op = o;
    c_addr = ad;
    c_data = dt;
    repeat (3) @(posedge clk);
    #1 valid = 1'b0;
    op = 2'($random(seed));
    // a hang is caught by the cycle ceiling, which counts a mismatch
    while (done !== 1'b1) begin
      @(posedge clk);
      #1 ce = ($random(seed) & 7) != 0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    valid = 1'b0;
    op = OP_READ;
    c_addr = '0;
    c_data = 8'h00;
    foreach (shadow[i]) shadow[i] = 8'hFF;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    chk("busy", 8'h00, {7'h00, busy});
    chk("supply", 8'h00, {7'h00, vpp});
    chk("device cmd", 8'h00, u_flash.cmd_ff);
    $display("test reset done");
    repeat (4) begin
      a = AW'($random(seed) & 3);
      d = 8'($random(seed));
      run_op(OP_PROG, a, d);
      chk("prog fail", exp_fail(shadow[a], d), {7'h00, fail});
      shadow[a] &= d;
      run_op(OP_READ, a, 8'h00);
      chk("read back", shadow[a], rd_data);
    end
    $display("test random program done");
    u_flash.drop_p = 2;
    run_op(OP_PROG, 3'h7, 8'h5A);
    chk("retry fail", 8'h00, {7'h00, fail});
    chk("retry data", 8'h5A, u_flash.mem[7]);
    u_flash.drop_p = 4;
    run_op(OP_PROG, 3'h6, 8'h00);
    chk("limit fail", 8'h01, {7'h00, fail});
    chk("limit data", 8'hFF, u_flash.mem[6]);
    $display("test program retry done");
    u_flash.drop_e = 1;
    run_op(OP_ERASE, 3'h0, 8'h00);
    chk("erase fail", 8'h00, {7'h00, fail});
    chk("preprogram", 8'h00, {7'h00, pre_err});
    for (int i = 0; i < 2**AW; i++) chk("erased", 8'hFF, u_flash.mem[i]);
    chk("read cmd", 8'h00, u_flash.cmd_ff);
    $display("test erase done");
    u_flash.cmd_ff = 8'h40;
    run_op(OP_RESET, 3'h0, 8'h00);
    chk("reset cmd", 8'h00, u_flash.cmd_ff);
    chk("reset data", 8'hFF, u_flash.mem[0]);
    $display("test reset op done");
    complete_run();
  end
endmodule // fpc_host_tb
